// [mvar_regs.sv]
`timescale 1ns/1ns
module mvar_regs
	import mvar_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// register access from the serial control port
	input wire mvar_req_t req,
	output logic [7:0] rdata,
	output logic hit,
	// device configuration from elsewhere
	input wire logic freeze,
	input wire logic [1:0] crossing_wait_mode,
	input wire logic zero_cross,
	input wire logic timeout_pulse,
	// applied master settings
	output mvar_level_t second_master_level,
	output mvar_level_t third_master_level,
	output logic second_master_silence,
	output logic third_master_silence,
	output logic [7:0] second_master_channel_select,
	output logic [7:0] third_master_channel_select,
	output logic [7:0] second_master_clamped,
	output logic [7:0] third_master_clamped,
	// addressing
	output logic [6:0] first_group_id,
	output logic [6:0] second_group_id,
	output logic [6:0] own_device_id,
	output logic first_group_accept,
	output logic second_group_accept,
	output logic chain_enable_out
);
	// shadow registers take writes, live copies drive the hardware
	logic [7:0] sel2_r, sel3_r, lvl2_r, lvl3_r;
	logic [1:0] ctl2_r, ctl3_r;
	logic [7:0] g1_r, g2_r, own_r;
	logic [7:0] sel2_live_r, sel3_live_r;
	logic [1:0] ctl2_live_r, ctl3_live_r;
	logic [7:0] g1_live_r, g2_live_r, own_live_r;
	logic [7:0] lvl2_tgt_r, lvl3_tgt_r;
	logic [7:0] lvl2_out_r, lvl3_out_r;
	logic pend2_r, pend3_r;
	// the change that waits for a crossing, one per master
	logic [7:0] pval2_r, pval3_r;
	logic [7:0] rdata_nxt;
	logic hit_nxt;

	// limit a code to the analog range, as the gain stages cannot go further
	function automatic logic [7:0] clamp_code(input logic [7:0] c);
		if (c > MVAR_CODE_MAX)
			return MVAR_CODE_MAX;
		else if (c < MVAR_CODE_MIN)
			return MVAR_CODE_MIN;
		return c;
	endfunction

	function automatic logic is_wr(input mvar_req_t r, input logic [7:0] a);
		return r.wr && (r.addr == a);
	endfunction

	// mode 11 is reserved; treating it like 00 keeps a stray setting
	// from leaving a level change stranded for good
	function automatic logic applies_now(input logic [1:0] m);
		return m == MVAR_ZC_NOW || m == 2'h3;
	endfunction

	// write path overview:
	// - host bytes land in shadow registers on the edge they are taken
	// - shadows are copied to live state on every edge freeze is low
	// - levels pass one more stage that waits for a crossing if asked
	// so read-back shows a write one edge on, the applied outputs two
	// edges on, and a level in mode 00 three edges on

	// host writes land in shadows; the nine addresses 0x13-0x1b accepted at any time
	// own id writable
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sel2_r <= MVAR_RST_SEL;
			sel3_r <= MVAR_RST_SEL;
			lvl2_r <= MVAR_RST_LVL;
			lvl3_r <= MVAR_RST_LVL;
			ctl2_r <= 2'h0;
			ctl3_r <= 2'h0;
			g1_r <= {MVAR_RST_ID, 1'b0};
			g2_r <= {MVAR_RST_ID, 1'b0};
			own_r <= {MVAR_RST_ID, 1'b0};
		end else begin
			if (is_wr(req, MVAR_OFS_M2_SEL))
				sel2_r <= req.wdata;
			if (is_wr(req, MVAR_OFS_M3_SEL))
				sel3_r <= req.wdata;
			if (is_wr(req, MVAR_OFS_M2_LVL))
				lvl2_r <= req.wdata;
			if (is_wr(req, MVAR_OFS_M3_LVL))
				lvl3_r <= req.wdata;
			if (is_wr(req, MVAR_OFS_M2_CTL))
				ctl2_r <= req.wdata[1:0];
			if (is_wr(req, MVAR_OFS_M3_CTL))
				ctl3_r <= req.wdata[1:0];
			if (is_wr(req, MVAR_OFS_G2_ADR))
				g2_r <= req.wdata;
			if (is_wr(req, MVAR_OFS_G1_ADR))
				g1_r <= req.wdata;
			if (is_wr(req, MVAR_OFS_OWN_ADR))
				own_r <= req.wdata;
		end
	end

	// copy shadows to live state unless frozen
	// freeze holds changes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sel2_live_r <= MVAR_RST_SEL;
			sel3_live_r <= MVAR_RST_SEL;
			ctl2_live_r <= 2'h0;
			ctl3_live_r <= 2'h0;
			g1_live_r <= {MVAR_RST_ID, 1'b0};
			g2_live_r <= {MVAR_RST_ID, 1'b0};
			own_live_r <= {MVAR_RST_ID, 1'b0};
			lvl2_tgt_r <= MVAR_RST_LVL;
			lvl3_tgt_r <= MVAR_RST_LVL;
		end else if (!freeze) begin
			sel2_live_r <= sel2_r;
			sel3_live_r <= sel3_r;
			ctl2_live_r <= ctl2_r;
			ctl3_live_r <= ctl3_r;
			g1_live_r <= g1_r;
			g2_live_r <= g2_r;
			own_live_r <= own_r;
			lvl2_tgt_r <= lvl2_r;
			lvl3_tgt_r <= lvl3_r;
		end
	end

	// level application per crossing mode
	// one change may wait per master: pval holds it, pend marks it.
	// the wait is timed outside this block; only the crossing and
	// time-out strobes are seen here, so restarting the time-out on a
	// superseding change is the duty of whoever makes timeout_pulse.
	// a change that meets a strobe in the same cycle waits for the
	// next one: the strobe applies the older value first.
	// crossing mode steers levels
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lvl2_out_r <= MVAR_RST_LVL;
			pval2_r <= MVAR_RST_LVL;
			pend2_r <= 1'b0;
		end else if (applies_now(crossing_wait_mode)) begin
			lvl2_out_r <= lvl2_tgt_r;
			pval2_r <= lvl2_tgt_r;
			pend2_r <= 1'b0;
		end else if (!pend2_r) begin
			// a fresh change starts waiting
			if (lvl2_tgt_r != lvl2_out_r) begin
				pval2_r <= lvl2_tgt_r;
				pend2_r <= 1'b1;
			end
		end else if (zero_cross || timeout_pulse) begin
			lvl2_out_r <= pval2_r;
			pend2_r <= 1'b0;
		end else if (lvl2_tgt_r != pval2_r) begin
			// supersede: 10 applies the old, 01 drops it
			if (crossing_wait_mode == MVAR_ZC_PUSH)
				lvl2_out_r <= pval2_r;
			pval2_r <= lvl2_tgt_r;
		end
	end

	// same scheme for the third master
	// third master waits alike
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lvl3_out_r <= MVAR_RST_LVL;
			pval3_r <= MVAR_RST_LVL;
			pend3_r <= 1'b0;
		end else if (applies_now(crossing_wait_mode)) begin
			lvl3_out_r <= lvl3_tgt_r;
			pval3_r <= lvl3_tgt_r;
			pend3_r <= 1'b0;
		end else if (!pend3_r) begin
			if (lvl3_tgt_r != lvl3_out_r) begin
				pval3_r <= lvl3_tgt_r;
				pend3_r <= 1'b1;
			end
		end else if (zero_cross || timeout_pulse) begin
			lvl3_out_r <= pval3_r;
			pend3_r <= 1'b0;
		end else if (lvl3_tgt_r != pval3_r) begin
			// a dropped change in mode 01 never reaches the output
			if (crossing_wait_mode == MVAR_ZC_PUSH)
				lvl3_out_r <= pval3_r;
			pval3_r <= lvl3_tgt_r;
		end
	end

	// read decode, registered so data comes from flip-flops
	// reserved bits read zero
	always_comb begin
		rdata_nxt = 8'h00;
		hit_nxt = 1'b1;
		case (req.addr)
			MVAR_OFS_M2_SEL: rdata_nxt = sel2_r;
			MVAR_OFS_M2_LVL: rdata_nxt = lvl2_r;
			MVAR_OFS_M2_CTL: rdata_nxt = {6'h00, ctl2_r};
			MVAR_OFS_M3_SEL: rdata_nxt = sel3_r;
			MVAR_OFS_M3_LVL: rdata_nxt = lvl3_r;
			MVAR_OFS_M3_CTL: rdata_nxt = {6'h00, ctl3_r};
			MVAR_OFS_G2_ADR: rdata_nxt = g2_r;
			MVAR_OFS_G1_ADR: rdata_nxt = g1_r;
			MVAR_OFS_OWN_ADR: rdata_nxt = own_r;
			MVAR_OFS_IDENT: rdata_nxt = {MVAR_PART_CODE, MVAR_REV_CODE};
			default: hit_nxt = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= 8'h00;
			hit <= 1'b0;
		end else if (req.rd) begin
			rdata <= rdata_nxt;
			hit <= hit_nxt;
		end
	end

	// outputs toward channel logic
	// quarter step passed on
	assign second_master_level = '{code: lvl2_out_r,
		quarter: ctl2_live_r[MVAR_QTR_BIT]};
	assign third_master_level = '{code: lvl3_out_r,
		quarter: ctl3_live_r[MVAR_QTR_BIT]};
	assign second_master_silence = ctl2_live_r[MVAR_SIL_BIT];
	assign third_master_silence = ctl3_live_r[MVAR_SIL_BIT];
	assign second_master_channel_select = sel2_live_r;
	assign third_master_channel_select = sel3_live_r;
	assign second_master_clamped = clamp_code(lvl2_out_r);
	assign third_master_clamped = clamp_code(lvl3_out_r);
	assign first_group_id = g1_live_r[7:1];
	assign second_group_id = g2_live_r[7:1];
	assign own_device_id = own_live_r[7:1];
	assign first_group_accept = g1_live_r[MVAR_ACC_BIT];
	assign second_group_accept = g2_live_r[MVAR_ACC_BIT];
	assign chain_enable_out = own_live_r[MVAR_ACC_BIT];
endmodule

// [mvar_pkg.sv]
package mvar_pkg;
	localparam logic [7:0] MVAR_OFS_M2_SEL = 8'h13;
	localparam logic [7:0] MVAR_OFS_M2_LVL = 8'h14;
	localparam logic [7:0] MVAR_OFS_M2_CTL = 8'h15;
	localparam logic [7:0] MVAR_OFS_M3_SEL = 8'h16;
	localparam logic [7:0] MVAR_OFS_M3_LVL = 8'h17;
	localparam logic [7:0] MVAR_OFS_M3_CTL = 8'h18;
	localparam logic [7:0] MVAR_OFS_G2_ADR = 8'h19;
	localparam logic [7:0] MVAR_OFS_G1_ADR = 8'h1a;
	localparam logic [7:0] MVAR_OFS_OWN_ADR = 8'h1b;
	localparam logic [7:0] MVAR_OFS_IDENT = 8'h1c;
	localparam logic [7:0] MVAR_RST_SEL = 8'hff;
	localparam logic [7:0] MVAR_RST_LVL = 8'hd2;
	localparam logic [7:0] MVAR_RST_CTL = 8'h00;
	localparam logic [6:0] MVAR_RST_ID = 7'h40;
	localparam int MVAR_QTR_BIT = 0;
	localparam int MVAR_SIL_BIT = 1;
	localparam int MVAR_ACC_BIT = 0;
	// half-dB codes bounding the analog range: 2*22+210 and 2*(-96)+210
	localparam logic [7:0] MVAR_CODE_MAX = 8'hfe;
	localparam logic [7:0] MVAR_CODE_MIN = 8'h12;
	// arbitrary neutral identity values
	localparam logic [3:0] MVAR_PART_CODE = 4'h5;
	localparam logic [3:0] MVAR_REV_CODE = 4'h0;
	localparam logic [1:0] MVAR_ZC_NOW = 2'h0;
	localparam logic [1:0] MVAR_ZC_DROP = 2'h1;
	localparam logic [1:0] MVAR_ZC_PUSH = 2'h2;

	typedef struct packed {
		logic [7:0] code;
		logic quarter;
	} mvar_level_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mvar_req_t;
endpackage

// [mvar_regs_props.sv]
`timescale 1ns/1ns
module mvar_regs_props
	import mvar_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// register port and controls
	input wire mvar_req_t req,
	input wire logic [7:0] rdata,
	input wire logic hit,
	input wire logic freeze,
	input wire logic [1:0] crossing_wait_mode,
	// applied state
	input wire mvar_level_t second_master_level,
	input wire logic second_master_silence,
	input wire logic [7:0] second_master_channel_select,
	input wire logic [7:0] second_master_clamped,
	input wire logic first_group_accept,
	input wire logic chain_enable_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// a write taken with freeze low both cycles lands two edges on
	sequence w_at(logic [7:0] a);
		req.wr && req.addr == a && !freeze ##1 !freeze;
	endsequence
	a_ident_read: assert property (req.rd && req.addr == 8'h1c
		|=> hit && rdata == {MVAR_PART_CODE, MVAR_REV_CODE})
		else $error("identity read wrong");
	a_unmapped_read: assert property (req.rd && req.addr > 8'h1c
		|=> !hit && rdata == 8'h00) else $error("unmapped read hit");
	a_ctl_reserved: assert property (req.rd && req.addr == 8'h15
		|=> rdata[7:2] == 6'h00) else $error("reserved bits set");
	a_silence_apply: assert property (w_at(MVAR_OFS_M2_CTL)
		|=> second_master_silence == $past(req.wdata[1], 2))
		else $error("silence not applied");
	a_select_apply: assert property (w_at(MVAR_OFS_M2_SEL)
		|=> second_master_channel_select == $past(req.wdata, 2))
		else $error("channel select not applied");
	a_chain_apply: assert property (w_at(MVAR_OFS_OWN_ADR)
		|=> chain_enable_out == $past(req.wdata[0], 2))
		else $error("chain output wrong");
	a_accept_apply: assert property (w_at(MVAR_OFS_G1_ADR)
		|=> first_group_accept == $past(req.wdata[0], 2))
		else $error("group accept wrong");
	a_level_now: assert property ((w_at(MVAR_OFS_M2_LVL)
		and crossing_wait_mode == 2'h0 [*2]) ##1 crossing_wait_mode == 2'h0
		|=> second_master_level.code == $past(req.wdata, 3))
		else $error("level not applied at once");
	a_clamp_range: assert property (second_master_clamped ==
		(second_master_level.code > MVAR_CODE_MAX ? MVAR_CODE_MAX :
		second_master_level.code < MVAR_CODE_MIN ? MVAR_CODE_MIN :
		second_master_level.code)) else $error("clamp wrong");
	a_freeze_hold: assert property (freeze [*3]
		|-> $stable(second_master_channel_select))
		else $error("change while frozen");
	c_write: cover property (w_at(MVAR_OFS_M2_SEL));
	c_freeze: cover property (freeze [*3]);
	c_ident: cover property (req.rd && req.addr == 8'h1c);
endmodule
bind mvar_regs mvar_regs_props i_mvar_regs_props (.clk, .resetn, .req,
	.rdata, .hit, .freeze, .crossing_wait_mode, .second_master_level,
	.second_master_silence, .second_master_channel_select,
	.second_master_clamped, .first_group_accept, .chain_enable_out);

// [mvar_host.sv]
`timescale 1ns/1ns
module mvar_host
	import mvar_pkg::*;
(
	// clock
	input wire logic clk,
	// request toward the bank and its answer
	output mvar_req_t req,
	input wire logic [7:0] rdata,
	input wire logic hit
);
	// idle fields are inverted so stale values never look valid
	initial req = '0;
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	// read answer is taken once the edge after the strobe settles
	task automatic get(input logic [7:0] a, output logic [7:0] d,
		output logic h);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
		#1;
		d = rdata;
		h = hit;
	endtask
	task automatic level(input int q);
		put(MVAR_OFS_M2_LVL, 8'hd2 + 8'(q >>> 1));
		put(MVAR_OFS_M2_CTL, {7'h00, q[0]});
	endtask
endmodule

// [mvar_regs_test.sv]
`timescale 1ns/1ns
module mvar_regs_test
	import mvar_pkg::*;
;
	logic clk, resetn = 1'b0, freeze = 1'b0, zc = 1'b0, tout = 1'b0;
	logic [1:0] mode = 2'h0;
	mvar_req_t req;
	mvar_level_t lvl2;
	logic [7:0] rdata, got, prv, sel2, clp2;
	logic [6:0] g1, own;
	logic hit, h, sil2, a1, chain;
	int n_errors = 0, checks = 0;
	logic [7:0] rst_tab [9] = '{8'hff, 8'hd2, 8'h00, 8'hff, 8'hd2, 8'h00,
		8'h80, 8'h80, 8'h80};
	// device under test and host model
	mvar_regs i_mvar_regs (.clk(clk), .resetn(resetn), .req(req),
		.rdata(rdata), .hit(hit), .freeze(freeze),
		.crossing_wait_mode(mode), .zero_cross(zc), .timeout_pulse(tout),
		.second_master_level(lvl2), .third_master_level(),
		.second_master_silence(sil2), .third_master_silence(),
		.second_master_channel_select(sel2),
		.third_master_channel_select(), .second_master_clamped(clp2),
		.third_master_clamped(), .first_group_id(g1),
		.second_group_id(), .own_device_id(own),
		.first_group_accept(a1), .second_group_accept(),
		.chain_enable_out(chain));
	mvar_host i_mvar_host (.clk(clk), .req(req), .rdata(rdata), .hit(hit));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		i_mvar_host.get(a, got, h);
		chk(got, e);
		chk({7'h00, h}, 8'h01);
	endtask
	// applied outputs trail a write by two edges, a level in mode 00 by three
	task automatic pause;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// watchdog far beyond the hundred or so cycles the tests need
	initial begin
		#200000;
		n_errors++;
		close_out;
	end
	initial begin
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			rdchk(8'h13 + 8'(i), rst_tab[i]);
		end
		rdchk(MVAR_OFS_IDENT, 8'h50);
		i_mvar_host.get(8'h20, got, h);
		chk({7'h00, h}, 8'h00);
		chk(got, 8'h00);
		$display("reset test done");
		i_mvar_host.put(MVAR_OFS_M2_CTL, 8'hff);
		rdchk(MVAR_OFS_M2_CTL, 8'h03);
		chk({7'h00, sil2}, 8'h01);
		i_mvar_host.put(MVAR_OFS_M2_SEL, 8'h5a);
		i_mvar_host.put(MVAR_OFS_OWN_ADR, 8'h35);
		i_mvar_host.put(MVAR_OFS_G1_ADR, 8'h0b);
		i_mvar_host.put(MVAR_OFS_IDENT, 8'h00);
		rdchk(MVAR_OFS_IDENT, 8'h50);
		chk(sel2, 8'h5a);
		chk({own, chain}, 8'h35);
		chk({g1, a1}, 8'h0b);
		i_mvar_host.level(3);
		pause;
		chk(lvl2.code, 8'hd3);
		chk({6'h00, lvl2.quarter, sil2}, 8'h02);
		i_mvar_host.put(MVAR_OFS_M2_LVL, 8'hff);
		pause;
		chk(clp2, MVAR_CODE_MAX);
		i_mvar_host.put(MVAR_OFS_M2_LVL, 8'h00);
		pause;
		chk(clp2, MVAR_CODE_MIN);
		$display("write test done");
		freeze <= 1'b1;
		i_mvar_host.put(MVAR_OFS_M2_SEL, 8'h0f);
		pause;
		chk(sel2, 8'h5a);
		freeze <= 1'b0;
		pause;
		chk(sel2, 8'h0f);
		prv = 8'h00;
		// both waiting modes hold a change until a crossing or time-out; a second
		// change while waiting drops the first in 01 and pushes it out in 10
		for (int m = 1; m < 3; m++) begin
			mode <= 2'(m);
			i_mvar_host.put(MVAR_OFS_M2_LVL, 8'h40 + 8'(m));
			pause;
			chk(lvl2.code, prv);
			i_mvar_host.put(MVAR_OFS_M2_LVL, 8'h50 + 8'(m));
			pause;
			chk(lvl2.code, (m == 2) ? 8'h40 + 8'(m) : prv);
			zc <= (m == 1);
			tout <= (m == 2);
			@(posedge clk);
			zc <= 1'b0;
			tout <= 1'b0;
			pause;
			prv = 8'h50 + 8'(m);
			chk(lvl2.code, prv);
		end
		// reserved mode acts at once
		mode <= 2'h3;
		i_mvar_host.put(MVAR_OFS_M2_LVL, 8'h60);
		pause;
		chk(lvl2.code, 8'h60);
		$display("freeze and crossing test done");
		close_out;
	end
endmodule
